// [logic/plsc_defs.svh]
// Constants for the port indicator and strap configuration block
`ifndef PLSC_DEFS_SVH
`define PLSC_DEFS_SVH

`define PLSC_PORTS 9
`define PLSC_STRAP_PORTS 8
`define PLSC_PINS_PER_PORT 4
`define PLSC_PIN_COUNT 36
`define PLSC_MODE_WIDTH 4
`define PLSC_SYNC_WIDTH 40

// Indicator slots within a port's group of four pins
`define PLSC_SLOT_SPEED 0
`define PLSC_SLOT_DUPLEX 1
`define PLSC_SLOT_EVENT 2
`define PLSC_SLOT_LINK 3

// Zero-based indicator groups that carry the copper straps (ports 1-4, ports 5-8)
`define PLSC_GRP_AN_LO 0
`define PLSC_GRP_AN_HI 1
`define PLSC_GRP_SPD_LO 2
`define PLSC_GRP_SPD_HI 3
`define PLSC_GRP_DUP_LO 4
`define PLSC_GRP_DUP_HI 8

// Mode codes with any of these bits set are factory test settings
`define PLSC_MODE_TEST_MASK 4'hc

// Timing
`define PLSC_CLK_PERIOD_NS 4
`define PLSC_SETTLE_CYCLES 4'h8
`define PLSC_SLOW_BLINK_MS 120
`define PLSC_FAST_BLINK_MS 30
`define PLSC_SLOW_BLINK_CYCLES ((`PLSC_SLOW_BLINK_MS * 1000000) / `PLSC_CLK_PERIOD_NS)
`define PLSC_FAST_BLINK_CYCLES ((`PLSC_FAST_BLINK_MS * 1000000) / `PLSC_CLK_PERIOD_NS)

`endif

// [logic/plsc_pkg.sv]
// Types shared by the port indicator and strap configuration block
package plsc_pkg;

  typedef struct packed {
    logic link;
    logic speed100;
    logic full_duplex;
    logic collision;
    logic tx_active;
    logic rx_active;
  } plsc_port_status_type;

  typedef struct packed {
    logic [7:0] an_enable;
    logic [7:0] force_100;
    logic [7:0] force_full;
  } plsc_strap_cfg_type;

  typedef enum logic [1:0] {
    PLSC_ST_SETTLE = 2'h0,
    PLSC_ST_CAPTURE = 2'h1,
    PLSC_ST_RUN = 2'h2
  } plsc_state_type;

  typedef enum logic [1:0] {
    PLSC_MODE0 = 2'h0,
    PLSC_MODE1 = 2'h1,
    PLSC_MODE2 = 2'h2,
    PLSC_MODE3 = 2'h3
  } plsc_led_mode_type;

endpackage : plsc_pkg

// [logic/plsc_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module plsc_pin_sync #(
  parameter int WIDTH = 40
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] filt,
  output logic agree
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // Idle value is all ones: an undriven strap floats to the default
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt <= '1;
      agree <= 1'b0;
    end else begin
      agree <= (s2 == s3);
      if (s2 == s3) begin
        filt <= s3;
      end
    end
  end
endmodule : plsc_pin_sync

// [logic/plsc_blink.sv]
// Slow and fast blink phase generator for the activity indicators
`timescale 1ns/1ps
module plsc_blink #(
  parameter int unsigned SLOW_CYCLES = 30000000,
  parameter int unsigned FAST_CYCLES = 7500000
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic slow_phase,
  output logic fast_phase,
  output logic slow_tick
);
  logic [31:0] slow_cnt;
  logic [31:0] fast_cnt;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_cnt <= 32'h0;
      slow_phase <= 1'b0;
      slow_tick <= 1'b0;
    end else if (slow_cnt >= 32'(SLOW_CYCLES - 1)) begin
      slow_cnt <= 32'h0;
      slow_phase <= ~slow_phase;
      slow_tick <= 1'b1;
    end else begin
      slow_cnt <= slow_cnt + 32'h1;
      slow_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fast_cnt <= 32'h0;
      fast_phase <= 1'b0;
    end else if (fast_cnt >= 32'(FAST_CYCLES - 1)) begin
      fast_cnt <= 32'h0;
      fast_phase <= ~fast_phase;
    end else begin
      fast_cnt <= fast_cnt + 32'h1;
    end
  end
endmodule : plsc_blink

// [logic/plsc_top.sv]
// Port indicator drive and reset-time strap capture for a nine-port switch
// Function
// - Second indicator shows full duplex, modes 0-2
// - Mode 0 third indicator shows collision
// - Mode 1 third indicator shows transmit
// - Mode 2 third indicator: low-speed link activity
// - Mode 3 third: duplex solid, collision intermittent
// - Mode 0 fourth: link solid, traffic blinks
// - Mode 1 fourth indicator shows receive
// - Mode 2 fourth indicator: high-speed link activity
// - Mode 3 fourth indicator same as mode 0
// - Mode strap sampled at reset, held
// - Per-port strap disables auto-negotiation when low
// - Per-port speed strap, low forces 10
// - Per-port duplex strap, low forces full
// - First indicator: speed, combined, or collision
`timescale 1ns/1ps
`include "plsc_defs.svh"
module plsc_top #(
  parameter int unsigned SLOW_BLINK_CYCLES = `PLSC_SLOW_BLINK_CYCLES,
  parameter int unsigned FAST_BLINK_CYCLES = `PLSC_FAST_BLINK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`PLSC_PIN_COUNT-1:0] indicator_group_in,
  input wire logic [`PLSC_MODE_WIDTH-1:0] indicator_mode_strap,
  input plsc_pkg::plsc_port_status_type [`PLSC_PORTS-1:0] port_status,
  input wire logic [`PLSC_STRAP_PORTS-1:0] partner_an_able,
  output logic [`PLSC_PIN_COUNT-1:0] indicator_group_out,
  output logic [`PLSC_PIN_COUNT-1:0] indicator_group_oe,
  output plsc_pkg::plsc_strap_cfg_type strap_cfg,
  output plsc_pkg::plsc_led_mode_type led_mode,
  output logic cfg_valid,
  output logic factory_test,
  output logic [`PLSC_STRAP_PORTS-1:0] speed_force_en,
  output logic [`PLSC_STRAP_PORTS-1:0] duplex_force_en
);
  plsc_pkg::plsc_state_type state;
  logic [3:0] settle_cnt;
  logic [`PLSC_SYNC_WIDTH-1:0] pin_filt;
  logic pin_agree;
  logic slow_phase;
  logic fast_phase;
  logic slow_tick;
  logic [`PLSC_PORTS-1:0] act_seen;
  logic [`PLSC_PORTS-1:0] col_seen;
  logic [`PLSC_PIN_COUNT-1:0] next_on;
  logic [`PLSC_PIN_COUNT-1:0] strap_pins;
  logic [`PLSC_MODE_WIDTH-1:0] mode_pins;

  plsc_pin_sync #(
    .WIDTH(`PLSC_SYNC_WIDTH)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin({indicator_mode_strap, indicator_group_in}),
    .filt(pin_filt),
    .agree(pin_agree)
  );

  plsc_blink #(
    .SLOW_CYCLES(SLOW_BLINK_CYCLES),
    .FAST_CYCLES(FAST_BLINK_CYCLES)
  ) u_blink (
    .clk(clk),
    .sys_rst(sys_rst),
    .slow_phase(slow_phase),
    .fast_phase(fast_phase),
    .slow_tick(slow_tick)
  );

  assign strap_pins = pin_filt[`PLSC_PIN_COUNT-1:0];
  assign mode_pins = pin_filt[`PLSC_SYNC_WIDTH-1:`PLSC_PIN_COUNT];

  // Ports 1-4 sit on bits 3..0 of the low group, ports 5-8 on bits 3..0 of the high group
  function automatic logic [7:0] strap_pick(
    input logic [`PLSC_PIN_COUNT-1:0] pins,
    input int grp_lo,
    input int grp_hi
  );
    logic [7:0] r;
    r = 8'h0;
    for (int p = 0; p < 4; p++) begin
      r[p] = pins[grp_lo * 4 + 3 - p];
      r[p + 4] = pins[grp_hi * 4 + 3 - p];
    end
    return r;
  endfunction : strap_pick

  // Link with traffic: on, dark during the active half of the blink phase
  function automatic logic link_act(input logic link, input logic act, input logic phase);
    return link & ~(act & phase);
  endfunction : link_act

  // Straps settle through the synchroniser while no pin is driven
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= plsc_pkg::PLSC_ST_SETTLE;
      settle_cnt <= 4'h0;
    end else begin
      case (state)
        plsc_pkg::PLSC_ST_SETTLE: begin
          settle_cnt <= settle_cnt + 4'h1;
          if (settle_cnt == `PLSC_SETTLE_CYCLES - 4'h1) begin
            state <= plsc_pkg::PLSC_ST_CAPTURE;
          end
        end
        plsc_pkg::PLSC_ST_CAPTURE: begin
          if (pin_agree) begin
            state <= plsc_pkg::PLSC_ST_RUN;
          end
        end
        plsc_pkg::PLSC_ST_RUN: begin
          state <= plsc_pkg::PLSC_ST_RUN;
        end
        default: begin
          state <= plsc_pkg::PLSC_ST_SETTLE;
        end
      endcase
    end
  end

  // Captured once; later indicator traffic on the shared pins cannot reach these
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_cfg <= '{an_enable: 8'hff, force_100: 8'hff, force_full: 8'h00};
      led_mode <= plsc_pkg::PLSC_MODE0;
      factory_test <= 1'b0;
      cfg_valid <= 1'b0;
    end else if (state == plsc_pkg::PLSC_ST_CAPTURE && pin_agree) begin
      strap_cfg.an_enable <= strap_pick(strap_pins, `PLSC_GRP_AN_LO, `PLSC_GRP_AN_HI);
      strap_cfg.force_100 <= strap_pick(strap_pins, `PLSC_GRP_SPD_LO, `PLSC_GRP_SPD_HI);
      strap_cfg.force_full <= ~strap_pick(strap_pins, `PLSC_GRP_DUP_LO, `PLSC_GRP_DUP_HI);
      led_mode <= plsc_pkg::plsc_led_mode_type'(mode_pins[1:0]);
      // Test codes are flagged only; the block itself falls back to the low two bits
      factory_test <= |(mode_pins & `PLSC_MODE_TEST_MASK);
      cfg_valid <= 1'b1;
    end
  end

  // Speed straps only count with negotiation off; duplex also when the partner cannot negotiate
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      speed_force_en <= 8'h00;
      duplex_force_en <= 8'h00;
    end else if (cfg_valid) begin
      speed_force_en <= ~strap_cfg.an_enable;
      duplex_force_en <= ~strap_cfg.an_enable | ~partner_an_able;
    end
  end

  // Stretch short frames and collisions until the next slow blink tick, which may come one cycle later; set wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_seen <= '0;
      col_seen <= '0;
    end else begin
      for (int p = 0; p < `PLSC_PORTS; p++) begin
        act_seen[p] <= (port_status[p].tx_active | port_status[p].rx_active)
                       | (act_seen[p] & ~slow_tick);
        col_seen[p] <= port_status[p].collision | (col_seen[p] & ~slow_tick);
      end
    end
  end

  always_comb begin
    next_on = '0;
    for (int p = 0; p < `PLSC_PORTS; p++) begin
      case (led_mode)
        plsc_pkg::PLSC_MODE0: begin
          next_on[p*4+`PLSC_SLOT_SPEED] = port_status[p].speed100;
          next_on[p*4+`PLSC_SLOT_DUPLEX] = port_status[p].full_duplex;
          next_on[p*4+`PLSC_SLOT_EVENT] = port_status[p].collision;
          next_on[p*4+`PLSC_SLOT_LINK] = link_act(port_status[p].link, act_seen[p],
                                                  fast_phase);
        end
        plsc_pkg::PLSC_MODE1: begin
          next_on[p*4+`PLSC_SLOT_SPEED] = link_act(port_status[p].link, act_seen[p],
            port_status[p].speed100 ? fast_phase : slow_phase);
          next_on[p*4+`PLSC_SLOT_DUPLEX] = port_status[p].full_duplex;
          next_on[p*4+`PLSC_SLOT_EVENT] = port_status[p].tx_active;
          next_on[p*4+`PLSC_SLOT_LINK] = port_status[p].rx_active;
        end
        plsc_pkg::PLSC_MODE2: begin
          next_on[p*4+`PLSC_SLOT_SPEED] = port_status[p].collision;
          next_on[p*4+`PLSC_SLOT_DUPLEX] = port_status[p].full_duplex;
          next_on[p*4+`PLSC_SLOT_EVENT] = ~port_status[p].speed100
            & link_act(port_status[p].link, act_seen[p], fast_phase);
          next_on[p*4+`PLSC_SLOT_LINK] = port_status[p].speed100
            & link_act(port_status[p].link, act_seen[p], fast_phase);
        end
        plsc_pkg::PLSC_MODE3: begin
          next_on[p*4+`PLSC_SLOT_SPEED] = port_status[p].speed100;
          next_on[p*4+`PLSC_SLOT_DUPLEX] = 1'b0;
          next_on[p*4+`PLSC_SLOT_EVENT] = port_status[p].full_duplex
            | (col_seen[p] & fast_phase);
          next_on[p*4+`PLSC_SLOT_LINK] = link_act(port_status[p].link, act_seen[p],
                                                  fast_phase);
        end
        default: begin
          next_on[p*4+`PLSC_SLOT_SPEED] = 1'b0;
        end
      endcase
    end
  end

  // Pins stay released until the straps are captured, then drive low for on
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      indicator_group_out <= '1;
      indicator_group_oe <= '0;
    end else if (state == plsc_pkg::PLSC_ST_RUN) begin
      indicator_group_out <= ~next_on;
      indicator_group_oe <= '1;
    end else begin
      indicator_group_out <= '1;
      indicator_group_oe <= '0;
    end
  end

  a_oe_before_run: assert property (@(posedge clk) disable iff (sys_rst)
    !cfg_valid |-> indicator_group_oe == '0)
    else $error("indicator pins driven before strap capture");

  a_cfg_held: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_valid && $past(cfg_valid) |-> $stable(strap_cfg))
    else $error("captured strap configuration changed");

  a_mode_held: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_valid ##1 1'b1 |-> $stable(led_mode))
    else $error("indicator mode changed after capture");

  a_an_capture: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(cfg_valid) |-> strap_cfg.an_enable[0] == $past(pin_filt[3]))
    else $error("port 1 negotiation strap captured wrong");

  a_speed_capture: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(cfg_valid) |-> strap_cfg.force_100[4] == $past(pin_filt[15]))
    else $error("port 5 speed strap captured wrong");

  a_duplex_capture: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(cfg_valid) |-> strap_cfg.force_full[7] == !$past(pin_filt[32]))
    else $error("port 8 duplex strap captured wrong");

  a_duplex_led: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN && led_mode != plsc_pkg::PLSC_MODE3
    |=> indicator_group_out[1] == !$past(port_status[0].full_duplex))
    else $error("duplex indicator mismatch");

  a_col_led: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN && led_mode == plsc_pkg::PLSC_MODE0
    |=> indicator_group_out[2] == !$past(port_status[0].collision))
    else $error("collision indicator mismatch");

  a_tx_led: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN && led_mode == plsc_pkg::PLSC_MODE1
    && port_status[0].tx_active |=> !indicator_group_out[2])
    else $error("transmit indicator not lit");

  a_rx_led: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN && led_mode == plsc_pkg::PLSC_MODE1
    |=> indicator_group_out[3] == !$past(port_status[0].rx_active))
    else $error("receive indicator mismatch");

  a_nolink_dark: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN && !port_status[0].link
    && (led_mode == plsc_pkg::PLSC_MODE0 || led_mode == plsc_pkg::PLSC_MODE3)
    |=> indicator_group_out[3])
    else $error("link indicator lit without link");

  a_speed_split: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN && led_mode == plsc_pkg::PLSC_MODE2
    |=> indicator_group_out[2] | indicator_group_out[3])
    else $error("both speed activity indicators lit");

  a_full_solid: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN && led_mode == plsc_pkg::PLSC_MODE3
    && port_status[0].full_duplex |=> !indicator_group_out[2])
    else $error("full duplex indicator not solid");

  a_speed_led: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN && led_mode == plsc_pkg::PLSC_MODE0
    |=> indicator_group_out[0] == !$past(port_status[0].speed100))
    else $error("speed indicator mismatch");

  a_oe_in_run: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN
    |=> indicator_group_oe == '1)
    else $error("indicator pins released while running");

  a_reserved_off: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN && led_mode == plsc_pkg::PLSC_MODE3
    |=> indicator_group_out[1])
    else $error("reserved duplex indicator lit");

  a_link_blink: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN && led_mode == plsc_pkg::PLSC_MODE0
    && port_status[0].link && act_seen[0] && fast_phase |=> indicator_group_out[3])
    else $error("link indicator not dark in blink phase");

  a_force_speed: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_valid
    |=> speed_force_en == ~$past(strap_cfg.an_enable))
    else $error("speed force enable does not follow negotiation strap");

  a_mode2_col: assert property (@(posedge clk) disable iff (sys_rst)
    state == plsc_pkg::PLSC_ST_RUN && led_mode == plsc_pkg::PLSC_MODE2
    |=> indicator_group_out[0] == !$past(port_status[0].collision))
    else $error("collision indicator mismatch in mode 2");
endmodule : plsc_top

// [bench/plsc_board_model.sv]
// Board strap resistors and indicator lamps seen at the block's pins
`timescale 1ns/1ps
module plsc_board_model (
  input wire logic [35:0] strap_level,
  input wire logic [3:0] mode_level,
  input wire logic [35:0] pin_out,
  input wire logic [35:0] pin_oe,
  output logic [35:0] pin_level,
  output logic [3:0] mode_pin
);
  // An undriven pin settles to its resistor; a floating strap reads as the pull-up default
  always_comb begin
    for (int i = 0; i < 36; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : strap_level[i];
    end
  end
  // Normal boards hold the upper code bits low; the bench asks for a test code once
  assign mode_pin = mode_level;
endmodule : plsc_board_model

// [bench/tb_port_led_mux_and_strap_config.sv]
// Self-checking bench for the port indicator and strap configuration block
`timescale 1ns/1ps
`include "plsc_defs.svh"
module tb_port_led_mux_and_strap_config;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [35:0] strap_level = 36'hfffffffff;
  logic [3:0] mode_level = 4'h0;
  logic [35:0] pin_level;
  logic [3:0] mode_pin;
  plsc_pkg::plsc_port_status_type [8:0] port_status = '0;
  logic [7:0] partner_an_able = 8'h0f;
  logic [35:0] out;
  logic [35:0] oe;
  plsc_pkg::plsc_strap_cfg_type strap_cfg;
  plsc_pkg::plsc_led_mode_type led_mode;
  logic cfg_valid;
  logic factory_test;
  logic [7:0] speed_force_en;
  logic [7:0] duplex_force_en;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  // Short blink periods keep every blink pattern visible within a dozen cycles
  plsc_top #(.SLOW_BLINK_CYCLES(8), .FAST_BLINK_CYCLES(2)) plsc_top_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .indicator_group_in(pin_level),
    .indicator_mode_strap(mode_pin),
    .port_status(port_status),
    .partner_an_able(partner_an_able),
    .indicator_group_out(out),
    .indicator_group_oe(oe),
    .strap_cfg(strap_cfg),
    .led_mode(led_mode),
    .cfg_valid(cfg_valid),
    .factory_test(factory_test),
    .speed_force_en(speed_force_en),
    .duplex_force_en(duplex_force_en)
  );

  plsc_board_model plsc_board_model_inst (
    .strap_level(strap_level),
    .mode_level(mode_level),
    .pin_out(out),
    .pin_oe(oe),
    .pin_level(pin_level),
    .mode_pin(mode_pin)
  );

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("Run stopped after %0d cycles without finishing", cycles);
      complete_run();
    end
  end

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Port q strap sits in slot 3 - q%4 of its group, so port 1 is the top bit
  function automatic plsc_pkg::plsc_strap_cfg_type exp_cfg(input logic [35:0] s);
    plsc_pkg::plsc_strap_cfg_type c;
    int b;
    for (int q = 0; q < 8; q++) begin
      b = (q / 4) * 4 + 3 - q % 4;
      c.an_enable[q] = s[b];
      c.force_100[q] = s[b + 8];
      c.force_full[q] = ~s[(q < 4 ? 16 : 32) + 3 - q % 4];
    end
    return c;
  endfunction : exp_cfg

  task automatic do_reset(input logic [3:0] code, input logic [35:0] straps);
    plsc_pkg::plsc_strap_cfg_type c;
    int n;
    c = exp_cfg(straps);
    sys_rst = 1'b1;
    mode_level = code;
    strap_level = straps;
    port_status = '0;
    tick(6);
    check(40'(out), 40'hfffffffff);
    check(40'({oe, cfg_valid}), 40'h0);
    check(40'(strap_cfg), 40'hffff00);
    sys_rst = 1'b0;
    n = 0;
    while (cfg_valid !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    check(40'(n >= 8 && n < 40), 40'h1);
    check(40'(strap_cfg), 40'(c));
    check(40'(led_mode), 40'(code[1:0]));
    check(40'(factory_test), 40'(|code[3:2]));
    check(40'(oe), 40'h0);
    tick(1);
    check(40'(oe), 40'hfffffffff);
    check(40'(speed_force_en), 40'(c.an_enable ^ 8'hff));
    check(40'(duplex_force_en), 40'((c.an_enable & partner_an_able) ^ 8'hff));
  endtask : do_reset

  task automatic test_straps;
    plsc_pkg::plsc_strap_cfg_type c;
    c = exp_cfg(36'ha3c96a5c3);
    do_reset(4'h6, 36'ha3c96a5c3);
    // Straps moving after capture must not reach the configuration
    strap_level = ~36'ha3c96a5c3;
    partner_an_able = 8'hf0;
    tick(6);
    check(40'(strap_cfg), 40'(c));
    check(40'(led_mode), 40'h2);
    check(40'(duplex_force_en), 40'((c.an_enable ^ 8'hff) | 8'h0f));
  endtask : test_straps

  task automatic set_all(input logic [5:0] st);
    for (int p = 0; p < 9; p++) begin
      port_status[p] = plsc_pkg::plsc_port_status_type'(st);
    end
    tick(2);
  endtask : set_all

  // Kind 0 dark, 1 solid, 2 fast blink, 3 slow blink over twelve cycles at every port
  // Fast phase flips every two cycles, slow every eight, so the flip count tells them apart
  task automatic look(input int slot, input int kind);
    int lit [9];
    int flips [9];
    logic [8:0] prev;
    lit = '{default: 0};
    flips = '{default: 0};
    for (int p = 0; p < 9; p++) begin
      prev[p] = out[p * 4 + slot];
    end
    repeat (12) begin
      for (int p = 0; p < 9; p++) begin
        if (out[p * 4 + slot] === 1'b0) lit[p]++;
        if (out[p * 4 + slot] !== prev[p]) flips[p]++;
        prev[p] = out[p * 4 + slot];
      end
      tick(1);
    end
    for (int p = 0; p < 9; p++) begin
      check(40'(kind == 0 ? lit[p] == 0 : kind == 1 ? lit[p] == 12 :
                kind == 2 ? (lit[p] > 0 && lit[p] < 12 && flips[p] >= 4) :
                (lit[p] > 0 && lit[p] < 12 && flips[p] > 0 && flips[p] <= 2)),
            40'h1);
    end
  endtask : look

  task automatic test_mode0;
    do_reset(4'h0, 36'hfffffffff);
    set_all(6'b111100);
    look(0, 1);
    look(1, 1);
    look(2, 1);
    look(3, 1);
    set_all(6'b000000);
    look(0, 0);
    look(1, 0);
    look(2, 0);
    look(3, 0);
    set_all(6'b100010);
    look(3, 2);
  endtask : test_mode0

  task automatic test_mode1;
    do_reset(4'h1, 36'hfffffffff);
    set_all(6'b110010);
    look(1, 0);
    look(2, 1);
    look(3, 0);
    set_all(6'b110001);
    look(2, 0);
    look(3, 1);
    look(0, 2);
    set_all(6'b100001);
    look(0, 3);
  endtask : test_mode1

  task automatic test_mode2;
    do_reset(4'h2, 36'hfffffffff);
    set_all(6'b101100);
    look(0, 1);
    look(1, 1);
    look(2, 1);
    look(3, 0);
    set_all(6'b110000);
    look(0, 0);
    look(2, 0);
    look(3, 1);
    set_all(6'b100010);
    look(2, 2);
    look(3, 0);
    set_all(6'b110010);
    look(2, 0);
    look(3, 2);
  endtask : test_mode2

  task automatic test_mode3;
    do_reset(4'h3, 36'hfffffffff);
    set_all(6'b111000);
    look(0, 1);
    look(1, 0);
    look(2, 1);
    look(3, 1);
    set_all(6'b100000);
    look(0, 0);
    look(2, 0);
    set_all(6'b100100);
    look(2, 2);
    set_all(6'b100010);
    look(3, 2);
  endtask : test_mode3

  initial begin
    test_straps();
    test_mode0();
    test_mode1();
    test_mode2();
    test_mode3();
    complete_run();
  end
endmodule : tb_port_led_mux_and_strap_config
